// ---- hw/mcda_bdcalc.sv ----
`timescale 1ns/1ns
// Descriptor address former and circular queue index step
module mcda_bdcalc (
  input wire logic [31:0] base_i,
  input wire logic [15:0] offset_i,
  input wire logic [15:0] idx_i,
  input wire logic [15:0] qlen_i,
  output logic [31:0] addr_o,
  output logic [15:0] idx_next_o
);

  logic [15:0] rel;
  logic [15:0] idx_inc;

  // Offset inside the 64-Kbyte table, wrapping within it
  always_comb begin
    rel = 16'(offset_i + 16'(idx_i << mcda_pkg::BD_SHIFT));
    addr_o = base_i + {16'h0000, rel};
  end

  // Next descriptor, back to the queue start past the end
  always_comb begin
    idx_inc = 16'(idx_i + 16'h0001);
    idx_next_o = (idx_inc >= qlen_i) ? 16'h0000 : idx_inc;
  end

endmodule

// ---- hw/mcda_buf.sv ----
`timescale 1ns/1ns
// Two-entry buffer, head register drives the output directly
module mcda_buf #(
  parameter int unsigned W = 41
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
  logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic push, pop;

  // Next head and tail
  always_comb begin
    push = in_valid_i && !tail_v_r;
    pop = head_v_r && out_ready_i;
    head_v_nxt = head_v_r;
    head_nxt = head_r;
    tail_v_nxt = tail_v_r;
    tail_nxt = tail_r;
    if (pop) begin
      head_v_nxt = tail_v_r || push;
      head_nxt = tail_v_r ? tail_r : in_data_i;
      tail_v_nxt = tail_v_r && push;
      tail_nxt = in_data_i;
    end else if (push) begin
      if (head_v_r) begin
        tail_v_nxt = 1'b1;
        tail_nxt = in_data_i;
      end else begin
        head_v_nxt = 1'b1;
        head_nxt = in_data_i;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r <= '0;
      tail_r <= '0;
    end else begin
      head_v_r <= head_v_nxt;
      tail_v_r <= tail_v_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
    end
  end

  assign in_ready_o = !tail_v_r;
  assign out_valid_o = head_v_r;
  assign out_data_o = head_r;

endmodule

// ---- hw/mcda_engine.sv ----
`timescale 1ns/1ns
// Function
// - Each controller's parameter area sits 256 bytes after the previous one.
// - Global multichannel parameters take 0xAF bytes of the parameter area.
// - One 32-bit slot entry per slot: subchannel option, valid, channel pointer.
// - Device keeps receive and transmit current-slot pointers from the start pointers.
// - Channel address is six entry bits over six zero bits: 64-byte areas.
// - One channel parameter area serves both receive and transmit.
// - Slots with equal channel pointers merge into one logical channel.
// - Descriptor base is 32-bit table base plus channel's 16-bit offset.
// - Each channel walks its descriptors as a programmable circular queue.
// - A 32-bit buffer pointer from each descriptor addresses buffer memory.
// - Buffers up to 64 Kbytes, length from the descriptor length field; the engine never ends a length-0 buffer, its count wraps to 0.
// - 32 channels fit two slot tables, 64 channels only one shared.
// - Controllers splitting one TDM link may share one slot table.
// - Host loads receive current pointer at 0A; device advances it per slot.
module mcda_engine #(
  parameter int unsigned CTRL_INDEX = 0,
  parameter int unsigned CHANNELS = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_we_i,
  input wire logic host_re_i,
  input wire logic [12:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic slot_i,
  input wire logic slot_tx_i,
  input wire logic slot_last_i,
  input wire logic [7:0] slot_data_i,
  output logic slot_ready_o,
  output logic bd_req_o,
  output logic [31:0] bd_addr_o,
  input wire logic bd_ack_i,
  input wire logic [31:0] bd_ptr_i,
  input wire logic [15:0] bd_len_i,
  output logic xfer_valid_o,
  output logic xfer_tx_o,
  output logic [31:0] xfer_addr_o,
  output logic [7:0] xfer_data_o,
  input wire logic xfer_ready_i
);

  localparam logic [12:0] PBASE =
    13'(mcda_pkg::PRAM_BASE + 13'(CTRL_INDEX * mcda_pkg::AREA_SPACING));
  localparam int unsigned KEYS = 2 * CHANNELS;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] ram [mcda_pkg::RAM_WORDS];
  logic [15:0] idx_a [KEYS];
  logic [15:0] cnt_a [KEYS];
  logic [31:0] ptr_a [KEYS];
  logic [15:0] len_a [KEYS];
  logic [KEYS-1:0] ld_r, ld_nxt;

  mcda_pkg::mcda_state_t st_r, st_nxt;
  logic dir_r, dir_nxt, last_r, last_nxt;
  logic [7:0] data_r, data_nxt;
  logic [5:0] ch_r, ch_nxt;
  logic [15:0] rx_cur_r, rx_cur_nxt, tx_cur_r, tx_cur_nxt;
  logic [15:0] state_word_r, state_word_nxt;
  logic slot_ready_r, slot_ready_nxt;
  logic bd_req_r, bd_req_nxt;
  logic [31:0] bd_addr_r, bd_addr_nxt;
  logic [15:0] host_rdata_r, host_rdata_nxt;
  logic host_rvalid_r, host_rvalid_nxt;

  logic [12:0] g_off, ch_base;
  logic g_hit, wr_rx_cur, wr_tx_cur, wr_state;
  logic [15:0] cur, ent, start, ch_off, ch_qlen;
  logic [31:0] tbl_base, calc_addr;
  logic [15:0] idx_next, cnt_inc;
  logic [16:0] len_full;
  logic [6:0] key;
  logic load_bd, push_ok, buf_done;
  logic buf_in_ready;
  logic [40:0] buf_in, buf_out;

  function automatic logic [15:0] rd(input logic [12:0] a);
    rd = ram[a[12:1]];
  endfunction

  // ----------------------------------------
  // Host access to the internal RAM
  // ----------------------------------------

  // Global area decode, limited to the multichannel window
  always_comb begin
    g_off = 13'(host_addr_i - PBASE);
    g_hit = (host_addr_i >= PBASE) && (g_off < mcda_pkg::GLOBAL_BYTES);
    wr_rx_cur = host_we_i && g_hit && (g_off == mcda_pkg::OFF_RX_CUR);
    wr_tx_cur = host_we_i && g_hit && (g_off == mcda_pkg::OFF_TX_CUR);
    wr_state = host_we_i && g_hit && (g_off == mcda_pkg::OFF_STATE);
  end

  // RAM write port, host only
  always_ff @(posedge clk_i) begin
    if (host_we_i) begin
      ram[host_addr_i[12:1]] <= host_wdata_i;
    end
  end

  // Read data, live pointers shown instead of stale RAM words
  always_comb begin
    host_rvalid_nxt = host_re_i;
    host_rdata_nxt = host_rdata_r;
    if (host_re_i) begin
      if (g_hit && g_off == mcda_pkg::OFF_RX_CUR) begin
        host_rdata_nxt = rx_cur_r;
      end else if (g_hit && g_off == mcda_pkg::OFF_TX_CUR) begin
        host_rdata_nxt = tx_cur_r;
      end else if (g_hit && g_off == mcda_pkg::OFF_STATE) begin
        host_rdata_nxt = state_word_r;
      end else begin
        host_rdata_nxt = rd(host_addr_i);
      end
    end
  end

  // ----------------------------------------
  // Table lookups
  // ----------------------------------------

  // Entry, start pointer, channel area and table base
  always_comb begin
    cur = dir_r ? tx_cur_r : rx_cur_r;
    ent = rd(cur[12:0]);
    start = dir_r ? rd(13'(PBASE + mcda_pkg::OFF_TX_START))
                  : rd(13'(PBASE + mcda_pkg::OFF_RX_START));
    ch_base = {1'b0, ch_r, 6'h00};
    ch_off = dir_r ? rd(13'(ch_base + mcda_pkg::CH_TX_OFF))
                   : rd(13'(ch_base + mcda_pkg::CH_RX_OFF));
    ch_qlen = dir_r ? rd(13'(ch_base + mcda_pkg::CH_TX_QLEN))
                    : rd(13'(ch_base + mcda_pkg::CH_RX_QLEN));
    tbl_base = {rd(13'(PBASE + mcda_pkg::OFF_BASE_HI)),
                rd(13'(PBASE + mcda_pkg::OFF_BASE_LO))};
    key = {dir_r, ch_r};
    cnt_inc = 16'(cnt_a[key] + 16'h0001);
    len_full = (len_a[key] == 16'h0000) ? mcda_pkg::BUF_MAX : {1'b0, len_a[key]};
    buf_done = ({1'b0, cnt_inc} >= len_full);
    buf_in = {dir_r, 32'(ptr_a[key] + {16'h0000, cnt_a[key]}), data_r};
  end

  mcda_bdcalc u_bdcalc (
    .base_i(tbl_base),
    .offset_i(ch_off),
    .idx_i(idx_a[key]),
    .qlen_i(ch_qlen),
    .addr_o(calc_addr),
    .idx_next_o(idx_next)
  );

  // ----------------------------------------
  // Slot engine
  // ----------------------------------------

  // Next state of the walk
  always_comb begin
    st_nxt = st_r;
    dir_nxt = dir_r;
    last_nxt = last_r;
    data_nxt = data_r;
    ch_nxt = ch_r;
    rx_cur_nxt = rx_cur_r;
    tx_cur_nxt = tx_cur_r;
    bd_req_nxt = bd_req_r;
    bd_addr_nxt = bd_addr_r;
    ld_nxt = ld_r;
    load_bd = 1'b0;
    push_ok = 1'b0;
    case (st_r)
      mcda_pkg::ST_IDLE: begin
        if (slot_i && state_word_r[mcda_pkg::STATE_RUN_BIT]) begin
          dir_nxt = slot_tx_i;
          last_nxt = slot_last_i;
          data_nxt = slot_data_i;
          st_nxt = mcda_pkg::ST_ENTRY;
        end
      end
      mcda_pkg::ST_ENTRY: begin
        if (dir_r) begin
          tx_cur_nxt = last_r ? start : 16'(tx_cur_r + mcda_pkg::ENT_BYTES);
        end else begin
          rx_cur_nxt = last_r ? start : 16'(rx_cur_r + mcda_pkg::ENT_BYTES);
        end
        if (ent[mcda_pkg::ENT_VALID_BIT]) begin
          ch_nxt = ent[mcda_pkg::ENT_CH_MSB:mcda_pkg::ENT_CH_LSB];
          st_nxt = mcda_pkg::ST_CHECK;
        end else begin
          st_nxt = mcda_pkg::ST_IDLE;
        end
      end
      mcda_pkg::ST_CHECK: begin
        if (ld_r[key]) begin
          st_nxt = mcda_pkg::ST_XFER;
        end else begin
          bd_req_nxt = 1'b1;
          bd_addr_nxt = calc_addr;
          st_nxt = mcda_pkg::ST_FETCH;
        end
      end
      mcda_pkg::ST_FETCH: begin
        if (bd_ack_i) begin
          bd_req_nxt = 1'b0;
          load_bd = 1'b1;
          ld_nxt[key] = 1'b1;
          st_nxt = mcda_pkg::ST_XFER;
        end
      end
      mcda_pkg::ST_XFER: begin
        if (buf_in_ready) begin
          push_ok = 1'b1;
          if (buf_done) begin
            ld_nxt[key] = 1'b0;
          end
          st_nxt = mcda_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = mcda_pkg::ST_IDLE;
      end
    endcase
    if (wr_rx_cur) begin
      rx_cur_nxt = host_wdata_i;
    end
    if (wr_tx_cur) begin
      tx_cur_nxt = host_wdata_i;
    end
    state_word_nxt = wr_state ? host_wdata_i : state_word_r;
    slot_ready_nxt = (st_nxt == mcda_pkg::ST_IDLE);
  end

  // Engine registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= mcda_pkg::ST_IDLE;
      dir_r <= 1'b0;
      last_r <= 1'b0;
      data_r <= 8'h00;
      ch_r <= 6'h00;
      rx_cur_r <= 16'h0000;
      tx_cur_r <= 16'h0000;
      state_word_r <= mcda_pkg::STATE_RESET;
      slot_ready_r <= 1'b0;
      bd_req_r <= 1'b0;
      bd_addr_r <= 32'h0000_0000;
      ld_r <= '0;
      host_rdata_r <= 16'h0000;
      host_rvalid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dir_r <= dir_nxt;
      last_r <= last_nxt;
      data_r <= data_nxt;
      ch_r <= ch_nxt;
      rx_cur_r <= rx_cur_nxt;
      tx_cur_r <= tx_cur_nxt;
      state_word_r <= state_word_nxt;
      slot_ready_r <= slot_ready_nxt;
      bd_req_r <= bd_req_nxt;
      bd_addr_r <= bd_addr_nxt;
      ld_r <= ld_nxt;
      host_rdata_r <= host_rdata_nxt;
      host_rvalid_r <= host_rvalid_nxt;
    end
  end

  // Per-channel descriptor and buffer progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < KEYS; i++) begin
        idx_a[i] <= 16'h0000;
        cnt_a[i] <= 16'h0000;
      end
    end else if (load_bd) begin
      ptr_a[key] <= bd_ptr_i;
      len_a[key] <= bd_len_i;
      cnt_a[key] <= 16'h0000;
    end else if (push_ok) begin
      cnt_a[key] <= cnt_inc;
      if (buf_done) begin
        idx_a[key] <= idx_next;
      end
    end
  end

  // ----------------------------------------
  // Output buffer toward buffer memory
  // ----------------------------------------
  mcda_buf #(.W(41)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_ok),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in),
    .out_valid_o(xfer_valid_o),
    .out_ready_i(xfer_ready_i),
    .out_data_o(buf_out)
  );

  assign xfer_tx_o = buf_out[40];
  assign xfer_addr_o = buf_out[39:8];
  assign xfer_data_o = buf_out[7:0];
  assign host_rdata_o = host_rdata_r;
  assign host_rvalid_o = host_rvalid_r;
  assign slot_ready_o = slot_ready_r;
  assign bd_req_o = bd_req_r;
  assign bd_addr_o = bd_addr_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  rx_cur_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_rx_cur |=> rx_cur_r == $past(host_wdata_i))
    else $error("receive current pointer not loaded by host write");
  slot_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_ENTRY && !dir_r && !last_r && !wr_rx_cur
    |=> rx_cur_r == 16'($past(rx_cur_r) + mcda_pkg::ENT_BYTES))
    else $error("receive slot pointer did not step one entry");
  frame_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_ENTRY && dir_r && last_r && !wr_tx_cur
    |=> tx_cur_r == $past(start))
    else $error("transmit slot pointer not returned to start");
  invalid_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_ENTRY && !ent[mcda_pkg::ENT_VALID_BIT]
    |=> st_r == mcda_pkg::ST_IDLE && $stable(ld_r) && !bd_req_o)
    else $error("invalid slot entry reached a channel");
  chan_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_ENTRY && ent[mcda_pkg::ENT_VALID_BIT]
    |=> ch_base == {1'b0, $past(ent[mcda_pkg::ENT_CH_MSB:mcda_pkg::ENT_CH_LSB]), 6'h00})
    else $error("channel area address wrongly formed");
  bd_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(bd_req_o) |-> 32'(bd_addr_o - tbl_base) < 32'h0001_0000)
    else $error("descriptor address outside the table window");
  fetch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bd_req_o && !bd_ack_i |=> bd_req_o && $stable(bd_addr_o))
    else $error("descriptor request dropped before answer");
  ptr_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_FETCH && bd_ack_i && !push_ok
    |=> st_r == mcda_pkg::ST_XFER && buf_in[39:8] == $past(bd_ptr_i))
    else $error("first byte not at the fetched buffer pointer");
  run_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == mcda_pkg::ST_IDLE && slot_i && !state_word_r[mcda_pkg::STATE_RUN_BIT]
    |=> st_r == mcda_pkg::ST_IDLE)
    else $error("slot taken while controller stopped");

endmodule

// ---- hw/mcda_pkg.sv ----
package mcda_pkg;

  // ----------------------------------------
  // Internal RAM layout
  // ----------------------------------------
  localparam int unsigned RAM_WORDS = 4096;
  localparam logic [12:0] PRAM_BASE = 13'h1c00;
  localparam int unsigned AREA_SPACING = 256;
  localparam logic [12:0] GLOBAL_BYTES = 13'h00af;

  // ----------------------------------------
  // Global parameter offsets
  // ----------------------------------------
  localparam logic [12:0] OFF_BASE_HI = 13'h0000;
  localparam logic [12:0] OFF_BASE_LO = 13'h0002;
  localparam logic [12:0] OFF_STATE = 13'h0004;
  localparam logic [12:0] OFF_TX_START = 13'h0008;
  localparam logic [12:0] OFF_RX_CUR = 13'h000a;
  localparam logic [12:0] OFF_RX_START = 13'h001c;
  localparam logic [12:0] OFF_TX_CUR = 13'h001e;

  // ----------------------------------------
  // Channel area and slot entry layout
  // ----------------------------------------
  localparam logic [12:0] CH_RX_OFF = 13'h0000;
  localparam logic [12:0] CH_TX_OFF = 13'h0002;
  localparam logic [12:0] CH_RX_QLEN = 13'h0004;
  localparam logic [12:0] CH_TX_QLEN = 13'h0006;
  localparam int unsigned CH_AREA_BITS = 6;
  localparam int unsigned ENT_VALID_BIT = 15;
  localparam int unsigned ENT_CH_MSB = 11;
  localparam int unsigned ENT_CH_LSB = 6;
  localparam logic [15:0] ENT_BYTES = 16'h0004;
  localparam int unsigned BD_SHIFT = 3;
  localparam int unsigned STATE_RUN_BIT = 15;
  localparam logic [15:0] STATE_RESET = 16'h0000;
  localparam logic [16:0] BUF_MAX = 17'h10000;

  // ----------------------------------------
  // Engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ENTRY = 3'h1,
    ST_CHECK = 3'h3,
    ST_FETCH = 3'h2,
    ST_XFER = 3'h6
  } mcda_state_t;

endpackage

// ---- verification/mcda_partner.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Descriptor memory and buffer memory model
// ----------------------------------------
module mcda_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bd_req_i,
  input wire logic [31:0] bd_addr_i,
  output logic bd_ack_o,
  output logic [31:0] bd_ptr_o,
  output logic [15:0] bd_len_o,
  input wire logic xfer_valid_i,
  input wire logic xfer_tx_i,
  input wire logic [31:0] xfer_addr_i,
  input wire logic [7:0] xfer_data_i,
  output logic xfer_ready_o
);
  logic [31:0] ptr_of [logic [31:0]];
  logic [15:0] len_of [logic [31:0]];
  logic [31:0] log_addr [0:15];
  logic [7:0] log_data [0:15];
  logic log_tx [0:15];
  logic [31:0] last_bd = 32'h0;
  logic stall = 1'b0;
  int bd_wait = 0;
  int cnt = 0;
  int n_bd = 0;
  int n_xfer = 0;

  // Table at the unaligned base 0x80000004; length 0 is a full 64-Kbyte buffer
  initial begin
    ptr_of[32'h8000fffc] = 32'h00400000;
    len_of[32'h8000fffc] = 16'h0002;
    ptr_of[32'h80000004] = 32'h00500010;
    len_of[32'h80000004] = 16'h0002;
    ptr_of[32'h80000104] = 32'h00600000;
    len_of[32'h80000104] = 16'h0000;
  end

  // Answer after bd_wait cycles; idle data lines keep toggling
  always @(posedge clk_i) begin
    if (rst_i) begin
      bd_ack_o <= 1'b0;
      bd_ptr_o <= 32'h5a5a5a5a;
      bd_len_o <= 16'ha5a5;
      cnt <= 0;
    end else if (!bd_req_i || bd_ack_o) begin
      bd_ack_o <= 1'b0;
      bd_ptr_o <= ~bd_ptr_o;
      bd_len_o <= ~bd_len_o;
      cnt <= 0;
    end else if (cnt < bd_wait) begin
      cnt <= cnt + 1;
    end else begin
      bd_ack_o <= 1'b1;
      bd_ptr_o <= ptr_of.exists(bd_addr_i) ? ptr_of[bd_addr_i] : ~bd_addr_i;
      bd_len_o <= len_of.exists(bd_addr_i) ? len_of[bd_addr_i] : 16'h0001;
      last_bd <= bd_addr_i;
      n_bd <= n_bd + 1;
    end
  end

  // Consumer takes every access unless stalled, logging the first 16
  assign xfer_ready_o = ~stall;
  always @(posedge clk_i) begin
    if (!rst_i && xfer_valid_i && xfer_ready_o && n_xfer < 16) begin
      log_addr[n_xfer] <= xfer_addr_i;
      log_data[n_xfer] <= xfer_data_i;
      log_tx[n_xfer] <= xfer_tx_i;
      n_xfer <= n_xfer + 1;
    end
  end
endmodule

// ---- verification/multichannel_descriptor_addressing_bench.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Engine bench with host, slot source and far side model
// ----------------------------------------
module multichannel_descriptor_addressing_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_we_i = 1'b0;
  logic host_re_i = 1'b0;
  logic [12:0] host_addr_i = 13'h0000;
  logic [15:0] host_wdata_i = 16'h0000;
  logic slot_i = 1'b0;
  logic slot_tx_i = 1'b0;
  logic slot_last_i = 1'b0;
  logic [7:0] slot_data_i = 8'h00;
  logic [15:0] host_rdata_o, bd_len_i;
  logic host_rvalid_o, slot_ready_o, bd_req_o, bd_ack_i, xfer_valid_o, xfer_tx_o, xfer_ready_i;
  logic [31:0] bd_addr_o, bd_ptr_i, xfer_addr_o;
  logic [7:0] xfer_data_o;
  int fails = 0;
  int num_checks = 0;
  // Host setup: address in bits 28:16, data in 15:0; run bit written last
  logic [31:0] init_tab [0:16] = '{
    32'h1c008000, 32'h1c020004,
    32'h1c1c1c20, 32'h1c0a1c20, 32'h1c081c20, 32'h1c1e1c20,
    32'h1c208140, 32'h1c220000, 32'h1c240140, 32'h1c260000,
    32'h1c288140, 32'h1c2a0000, 32'h0140fff8, 32'h01420100,
    32'h01440002, 32'h01460001, 32'h1c048000};

  mcda_engine #(.CTRL_INDEX(0), .CHANNELS(64)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .host_we_i(host_we_i), .host_re_i(host_re_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .slot_i(slot_i), .slot_tx_i(slot_tx_i), .slot_last_i(slot_last_i),
    .slot_data_i(slot_data_i), .slot_ready_o(slot_ready_o), .bd_req_o(bd_req_o),
    .bd_addr_o(bd_addr_o), .bd_ack_i(bd_ack_i), .bd_ptr_i(bd_ptr_i), .bd_len_i(bd_len_i),
    .xfer_valid_o(xfer_valid_o), .xfer_tx_o(xfer_tx_o), .xfer_addr_o(xfer_addr_o),
    .xfer_data_o(xfer_data_o), .xfer_ready_i(xfer_ready_i));

  mcda_partner pm (.clk_i(clk_i), .rst_i(rst_i), .bd_req_i(bd_req_o), .bd_addr_i(bd_addr_o),
    .bd_ack_o(bd_ack_i), .bd_ptr_o(bd_ptr_i), .bd_len_o(bd_len_i),
    .xfer_valid_i(xfer_valid_o), .xfer_tx_i(xfer_tx_o), .xfer_addr_i(xfer_addr_o),
    .xfer_data_i(xfer_data_o), .xfer_ready_o(xfer_ready_i));

  // Clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Host write of one word
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    host_we_i = 1'b1;
    host_addr_i = a;
    host_wdata_i = d;
    @(posedge clk_i);
    #1;
    host_we_i = 1'b0;
  endtask

  // Host read; answer valid one cycle after the read edge
  task automatic rd(input logic [12:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    #1;
    host_re_i = 1'b1;
    host_addr_i = a;
    @(posedge clk_i);
    #1;
    host_re_i = 1'b0;
    chk(what, {15'h0, 1'b1, exp}, {15'h0, host_rvalid_o, host_rdata_o});
  endtask

  // One slot event, optionally waiting until the engine is idle again
  task automatic slot_go(input logic tx, input logic last, input logic [7:0] d, input logic wt);
    int k;
    @(posedge clk_i);
    #1;
    slot_i = 1'b1;
    slot_tx_i = tx;
    slot_last_i = last;
    slot_data_i = d;
    @(posedge clk_i);
    #1;
    slot_i = 1'b0;
    k = 0;
    while (wt && slot_ready_o !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (wt) chk("slot ready", 32'h1, {31'h0, slot_ready_o});
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Slot plus fetch, transfer and current pointer comparison
  task automatic step(input logic tx, input logic last, input logic [7:0] d,
                      input logic [31:0] nbd, input logic [31:0] bda, input logic [31:0] nx,
                      input logic [31:0] xa, input logic [15:0] cur);
    slot_go(tx, last, d, 1'b1);
    chk("fetch count", nbd, 32'(pm.n_bd));
    chk("descriptor address", bda, pm.last_bd);
    chk("transfer count", nx, 32'(pm.n_xfer));
    chk("transfer address", xa, pm.log_addr[nx-1]);
    chk("transfer kind and byte", {23'h0, tx, tx ? 8'h00 : d},
        {23'h0, pm.log_tx[nx-1], tx ? 8'h00 : pm.log_data[nx-1]});
    rd(tx ? 13'h1c1e : 13'h1c0a, cur, "current slot pointer");
  endtask

  task automatic t_reset();
    @(posedge clk_i);
    #1;
    chk("ready after reset", 32'h1, {31'h0, slot_ready_o});
    rd(13'h1c04, 16'h0000, "state word at reset");
    slot_go(1'b0, 1'b0, 8'h77, 1'b0);
    chk("slot refused when stopped", 32'h1, {31'h0, slot_ready_o});
    chk("no fetch when stopped", 32'h0, 32'(pm.n_bd));
    $display("test reset finished");
  endtask

  task automatic t_init();
    for (int i = 0; i < 17; i++) begin
      wr(init_tab[i][28:16], init_tab[i][15:0]);
    end
    rd(13'h1c00, 16'h8000, "table base upper");
    rd(13'h1c02, 16'h0004, "table base lower");
    rd(13'h1c04, 16'h8000, "state word");
    rd(13'h0146, 16'h0001, "tx queue length");
    wr(13'h1d0a, 16'h1234);
    rd(13'h1d0a, 16'h1234, "word in next controller area");
    $display("test init finished");
  endtask

  task automatic t_rx();
    pm.bd_wait = 3;
    step(0, 0, 8'ha5, 1, 32'h8000fffc, 1, 32'h00400000, 16'h1c24);
    step(0, 0, 8'ha5, 1, 32'h8000fffc, 1, 32'h00400000, 16'h1c28);
    step(0, 1, 8'h3c, 1, 32'h8000fffc, 2, 32'h00400001, 16'h1c20);
    pm.bd_wait = 0;
    step(0, 0, 8'h5e, 2, 32'h80000004, 3, 32'h00500010, 16'h1c24);
    step(0, 0, 8'h5e, 2, 32'h80000004, 3, 32'h00500010, 16'h1c28);
    step(0, 1, 8'hc3, 2, 32'h80000004, 4, 32'h00500011, 16'h1c20);
    step(0, 0, 8'h96, 3, 32'h8000fffc, 5, 32'h00400000, 16'h1c24);
    $display("test receive finished");
  endtask

  task automatic t_tx();
    step(1, 0, 8'h00, 4, 32'h80000104, 6, 32'h00600000, 16'h1c24);
    rd(13'h1c0a, 16'h1c24, "rx pointer kept");
    $display("test transmit finished");
  endtask

  task automatic t_stall();
    int k;
    pm.stall = 1'b1;
    step(1, 0, 8'h00, 4, 32'h80000104, 6, 32'h00600000, 16'h1c28);
    slot_go(1'b1, 1'b1, 8'h00, 1'b1);
    slot_go(1'b1, 1'b0, 8'h00, 1'b1);
    slot_go(1'b1, 1'b0, 8'h00, 1'b1);
    slot_go(1'b1, 1'b1, 8'h00, 1'b0);
    repeat (10) @(posedge clk_i);
    #1;
    chk("ready while full", 32'h0, {31'h0, slot_ready_o});
    chk("head held", {31'h0, 1'b1}, {31'h0, xfer_valid_o});
    chk("head address", 32'h00600001, xfer_addr_o);
    chk("count while stalled", 32'h6, 32'(pm.n_xfer));
    pm.stall = 1'b0;
    k = 0;
    while (slot_ready_o !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    repeat (6) @(posedge clk_i);
    #1;
    chk("count after drain", 32'h9, 32'(pm.n_xfer));
    for (int i = 6; i < 9; i++) begin
      chk("drained address", 32'h00600000 + 32'(i - 5), pm.log_addr[i]);
    end
    chk("buffer empty", 32'h0, {31'h0, xfer_valid_o});
    rd(13'h1c1e, 16'h1c20, "tx pointer wrapped");
    $display("test stall finished");
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    fails++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    chk("ready in reset", 32'h0, {31'h0, slot_ready_o});
    rst_i = 1'b0;
    t_reset();
    t_init();
    t_rx();
    t_tx();
    t_stall();
    test_done();
  end
endmodule
